// ==== design/uhl_cfg.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef UHL_CFG_SVH
`define UHL_CFG_SVH
`define UHL_OFS_IE_SET 12'h010
`define UHL_OFS_IE_CLR 12'h014
`define UHL_OFS_CAB 12'h018
`define UHL_OFS_PCUR 12'h01c
`define UHL_OFS_CHEAD 12'h020
`define UHL_OFS_CCUR 12'h024
`define UHL_OFS_BHEAD 12'h028
`define UHL_OFS_BCUR 12'h02c
`define UHL_OFS_DONE 12'h030
`define UHL_OFS_FLCFG 12'h034
`define UHL_OFS_FCD 12'h038
`define UHL_OFS_FNUM 12'h03c
`define UHL_OFS_STAT 12'h080
`define UHL_OFS_STATE 12'h084
`define UHL_IE_MASTER_BIT 31
`define UHL_IE_IMPL_MASK 32'h4000_006f
`define UHL_CAB_MASK 32'hffff_ff00
`define UHL_DESC_MASK 32'hffff_fff0
`define UHL_STAT_MASK 32'h4000_006f
`define UHL_SOF_BIT 2
`define UHL_FNO_BIT 5
`define UHL_FL_TOGGLE_BIT 31
`define UHL_FL_LDP_HI 30
`define UHL_FL_LDP_LO 16
`define UHL_FL_LEN_HI 13
`define UHL_FL_LEN_RST 14'h2edf
`define UHL_FL_LDP_RST 15'h0000
`define UHL_STATE_RESET 2'h0
`define UHL_STATE_RESUME 2'h1
`define UHL_STATE_RUN 2'h2
`define UHL_STATE_SUSPEND 2'h3
`define UHL_CLK_HZ 20000000
`define UHL_BIT_HZ 12000000
`define UHL_ACC_W 25
`define UHL_ACC_MOD 25'd20000000
`define UHL_ACC_STEP 25'd12000000
`endif

// ==== design/uhl_pkg.sv ====
// types shared by the frame and list register block
package uhl_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } uhl_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } uhl_apb_rsp_s;

  typedef enum logic [1:0] {
    UHL_AP_IDLE = 2'b01,
    UHL_AP_DONE = 2'b10
  } uhl_ap_e;

  typedef struct packed {
    uhl_ap_e ap;
    uhl_apb_rsp_s rsp;
    logic ie_master;
    logic [31:0] ie;
    logic [31:0] stat;
    logic [1:0] state;
    logic [31:0] cab;
    logic [31:0] pcur;
    logic [31:0] chead;
    logic [31:0] ccur;
    logic [31:0] bhead;
    logic [31:0] bcur;
    logic [31:0] done;
    logic fl_toggle;
    logic [14:0] fl_ldp;
    logic [13:0] fl_len;
    logic fc_toggle;
    logic [13:0] fc_count;
    logic [15:0] frame_counter;
    logic [14:0] ldp_counter;
    logic [24:0] acc;
    logic sof_pulse;
    logic irq;
  } uhl_state_s;
endpackage : uhl_pkg

// ==== design/uhl_regs.sv ====
// interrupt enable, list pointer and frame timing registers on apb
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "uhl_cfg.svh"

module uhl_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire uhl_pkg::uhl_apb_req_s apb_req,
  output uhl_pkg::uhl_apb_rsp_s apb_rsp,
  // events from neighbouring logic, one-cycle pulses
  input wire logic [31:0] event_set,
  // functional state written by the control logic
  input wire logic state_wr,
  input wire logic [1:0] state_wdata,
  // frame management outputs
  output logic irq,
  output logic sof_pulse,
  output logic [15:0] frame_counter,
  output logic [14:0] ldp_counter,
  output logic fc_toggle,
  output logic [13:0] fc_count
);
  import uhl_pkg::*;

  uhl_state_s r;
  uhl_state_s next_r;
  logic bit_tick;
  logic load;
  logic enter_run;
  logic [31:0] rdata;
  logic hit;
  logic [25:0] acc_sum;
  logic [31:0] wdat;

  // fractional divider: 12 MHz tick from 20 MHz clock, no second clock domain
  assign acc_sum = {1'b0, r.acc} + {1'b0, `UHL_ACC_STEP};
  assign bit_tick = acc_sum >= {1'b0, `UHL_ACC_MOD};

  // entering running state loads countdown even from a stopped counter
  assign enter_run = state_wr && state_wdata == `UHL_STATE_RUN
                     && r.state != `UHL_STATE_RUN;
  assign load = enter_run
                || (r.state == `UHL_STATE_RUN && bit_tick
                    && r.fc_count == 14'h0000);
  assign wdat = apb_req.pwdata;

  // read decode, unmapped offsets answer zero with an error
  always_comb
  begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (apb_req.paddr)
      `UHL_OFS_IE_SET,
      `UHL_OFS_IE_CLR: rdata = {r.ie_master, r.ie[30:0]};
      `UHL_OFS_CAB: rdata = r.cab;
      `UHL_OFS_PCUR: rdata = r.pcur;
      `UHL_OFS_CHEAD: rdata = r.chead;
      `UHL_OFS_CCUR: rdata = r.ccur;
      `UHL_OFS_BHEAD: rdata = r.bhead;
      `UHL_OFS_BCUR: rdata = r.bcur;
      `UHL_OFS_DONE: rdata = r.done;
      `UHL_OFS_FLCFG: rdata = {r.fl_toggle, r.fl_ldp, 2'b00, r.fl_len};
      `UHL_OFS_FCD: rdata = {r.fc_toggle, 17'h00000, r.fc_count};
      `UHL_OFS_FNUM: rdata = {16'h0000, r.frame_counter};
      `UHL_OFS_STAT: rdata = r.stat;
      `UHL_OFS_STATE: rdata = {30'h0000_0000, r.state};
      default: hit = 1'b0;
    endcase
  end

  // next state of the whole block
  always_comb
  begin
    next_r = r;
    next_r.sof_pulse = 1'b0;
    next_r.acc = bit_tick ? acc_sum[24:0] - `UHL_ACC_MOD : acc_sum[24:0];
    if (state_wr)
    begin
      next_r.state = state_wdata;
    end
    // frame countdown only moves while running or on the state write that enters running
    if (load)
    begin
      next_r.fc_count = r.fl_len;
      next_r.fc_toggle = r.fl_toggle;
      next_r.frame_counter = r.frame_counter + 16'h0001;
      next_r.ldp_counter = r.fl_ldp;
      next_r.sof_pulse = 1'b1;
    end
    else if (r.state == `UHL_STATE_RUN && bit_tick)
    begin
      next_r.fc_count = r.fc_count - 14'h0001;
    end
    // apb: no wait state, answer in the cycle after setup
    next_r.ap = UHL_AP_IDLE;
    next_r.rsp.pready = 1'b0;
    next_r.rsp.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable && r.ap == UHL_AP_IDLE)
    begin
      next_r.ap = UHL_AP_DONE;
      next_r.rsp.pready = 1'b1;
      next_r.rsp.pslverr = !hit;
      next_r.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
      if (apb_req.pwrite)
      begin
        case (apb_req.paddr)
          `UHL_OFS_IE_SET:
          begin
            if (wdat[`UHL_IE_MASTER_BIT])
            begin
              next_r.ie_master = 1'b1;
            end
            next_r.ie = r.ie | (wdat & `UHL_IE_IMPL_MASK);
          end
          `UHL_OFS_IE_CLR:
          begin
            if (wdat[`UHL_IE_MASTER_BIT])
            begin
              next_r.ie_master = 1'b0;
            end
            next_r.ie = r.ie & ~(wdat & `UHL_IE_IMPL_MASK);
          end
          `UHL_OFS_CAB: next_r.cab = wdat & `UHL_CAB_MASK;
          `UHL_OFS_PCUR: next_r.pcur = wdat & `UHL_DESC_MASK;
          `UHL_OFS_CHEAD: next_r.chead = wdat & `UHL_DESC_MASK;
          `UHL_OFS_CCUR: next_r.ccur = wdat & `UHL_DESC_MASK;
          `UHL_OFS_BHEAD: next_r.bhead = wdat & `UHL_DESC_MASK;
          `UHL_OFS_BCUR: next_r.bcur = wdat & `UHL_DESC_MASK;
          `UHL_OFS_DONE: next_r.done = wdat & `UHL_DESC_MASK;
          `UHL_OFS_FLCFG:
          begin
            // driver flips the toggle with each new length
            next_r.fl_toggle = wdat[`UHL_FL_TOGGLE_BIT];
            next_r.fl_ldp = wdat[`UHL_FL_LDP_HI:`UHL_FL_LDP_LO];
            next_r.fl_len = wdat[`UHL_FL_LEN_HI:0];
          end
          `UHL_OFS_STAT:
            next_r.stat = r.stat & ~(wdat & `UHL_STAT_MASK);
          default: next_r.ie = next_r.ie;
        endcase
      end
    end
    // events set status after any clear so a same-cycle event wins
    next_r.stat = next_r.stat | (event_set & `UHL_STAT_MASK);
    if (load)
    begin
      next_r.stat[`UHL_SOF_BIT] = 1'b1;
      if (next_r.frame_counter[15] != r.frame_counter[15])
      begin
        next_r.stat[`UHL_FNO_BIT] = 1'b1;
      end
    end
    next_r.irq = r.ie_master && |(r.stat & r.ie);
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.ap <= UHL_AP_IDLE;
      r.fl_len <= `UHL_FL_LEN_RST;
      r.fl_ldp <= `UHL_FL_LDP_RST;
      r.state <= `UHL_STATE_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign apb_rsp = r.rsp;
  assign irq = r.irq;
  assign sof_pulse = r.sof_pulse;
  assign frame_counter = r.frame_counter;
  assign ldp_counter = r.ldp_counter;
  assign fc_toggle = r.fc_toggle;
  assign fc_count = r.fc_count;
endmodule : uhl_regs

// ==== dv/uhl_regs_asserts.sv ====
// port-level checks for the frame and list register block
`timescale 1ns/1ps
module uhl_regs_chk (
  // clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire uhl_pkg::uhl_apb_req_s apb_req,
  input wire uhl_pkg::uhl_apb_rsp_s apb_rsp,
  // block outputs
  input wire logic irq,
  input wire logic sof_pulse,
  input wire logic [15:0] frame_counter,
  input wire logic fc_toggle,
  input wire logic [13:0] fc_count
);
  import uhl_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // one wait-free access phase, answer lasts a cycle
  ready_after_setup_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no pready after setup");
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held");
  err_with_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr alone");
  // master clear silences irq two edges after the setup
  master_off_a: assert property (apb_req.psel && !apb_req.penable && apb_req.pwrite
    && apb_req.paddr == 12'h014 && apb_req.pwdata[31] |-> ##2 !irq)
    else $error("irq after master clear");
  // toggle and frame number only move on a countdown load
  toggle_on_load_a: assert property (!sof_pulse |-> $stable(fc_toggle))
    else $error("toggle moved");
  fnum_hold_a: assert property (!sof_pulse |-> $stable(frame_counter))
    else $error("frame number moved");
  fnum_step_a: assert property (sof_pulse |-> frame_counter == 16'($past(frame_counter) + 1))
    else $error("frame number step");
  // countdown steps by one except at a load; zero ends the frame soon
  count_step_a: assert property (!sof_pulse && fc_count != $past(fc_count)
    |-> fc_count == 14'($past(fc_count) - 1))
    else $error("countdown step");
  reload_zero_a: assert property ($fell(|fc_count) |-> ##[1:3] sof_pulse)
    else $error("no reload at zero");
endmodule : uhl_regs_chk

bind uhl_regs uhl_regs_chk uhl_regs_chk_i (.pclk, .presetn, .apb_req, .apb_rsp, .irq,
  .sof_pulse, .frame_counter, .fc_toggle, .fc_count);

// ==== dv/uhl_regs_bench.sv ====
// self-checking bench for the frame and list register block
`timescale 1ns/1ps
module uhl_regs_bench;
  import uhl_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  uhl_apb_req_s apb_req = '0;
  uhl_apb_rsp_s apb_rsp;
  logic [31:0] event_set = '0;
  logic state_wr = 0;
  logic [1:0] state_wdata = '0;
  logic irq, sof_pulse, fc_toggle, err, s;
  logic [15:0] frame_counter;
  logic [14:0] ldp_counter;
  logic [13:0] fc_count;
  logic [31:0] rd, v, ie_m;
  logic [11:0] a;
  int error_cnt = 0;
  int n_compared = 0;
  always #25 pclk = ~pclk;
  uhl_regs uhl_regs_i (.pclk, .presetn, .apb_req, .apb_rsp, .event_set, .state_wr,
    .state_wdata, .irq, .sof_pulse, .frame_counter, .ldp_counter, .fc_toggle, .fc_count);
  // verdict and the only exit
  task automatic stop_test;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  // bounded wait for a flag; running out ends the run
  task automatic wait_hi(input bit is_sof);
    int n;
    for (n = 0; n < 200; n++)
    begin
      @(posedge pclk);
      if ((is_sof ? sof_pulse : apb_rsp.pready) === 1'b1)
        break;
    end
    if (n == 200)
    begin
      cmp(1, 0);
      stop_test();
    end
  endtask : wait_hi
  // request held until pready is sampled, then released
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{paddr: ad, psel: 1, penable: 0, pwrite: w, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1;
    wait_hi(0);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb
  task automatic rchk(input logic [11:0] ad, input logic [31:0] exp);
    apb(0, ad, 0);
    cmp(rd, exp);
  endtask : rchk
  // implemented enables only; bit 4 never sticks
  function automatic logic [31:0] ie_next(input logic [31:0] m, d, input logic set);
    return set ? m | (d & 32'hc000_006f) : m & ~(d & 32'hc000_006f);
  endfunction : ie_next
  initial
  begin
    v = $urandom(94694);
    repeat (10) @(posedge pclk);
    presetn <= 1;
    rchk(12'h034, 32'h0000_2edf);
    apb(0, 12'h0f0, 0);
    cmp(err, 1);
    // pointer registers keep their upper fields only
    for (int i = 0; i < 7; i++)
    begin
      a = 12'h018 + 12'(4 * i);
      v = $urandom;
      apb(1, a, v);
      rchk(a, v & (i == 0 ? 32'hffff_ff00 : 32'hffff_fff0));
    end
    // set/clear pair, all ones first then random, read back through the one just written
    ie_m = ie_next(0, 32'hffff_ffff, 1);
    s = 1'b1;
    apb(1, 12'h010, 32'hffff_ffff);
    for (int i = 0; i < 8; i++)
    begin
      rchk(s ? 12'h010 : 12'h014, ie_m);
      s = 1'($urandom);
      v = $urandom;
      ie_m = ie_next(ie_m, v, s);
      apb(1, s ? 12'h010 : 12'h014, v);
    end
    // one enabled event raises irq, master clear drops it
    apb(1, 12'h010, 32'h8000_0002);
    event_set <= 32'h2;
    @(posedge pclk);
    event_set <= 0;
    repeat (3) @(posedge pclk);
    cmp(irq, 1);
    apb(1, 12'h014, 32'h8000_0000);
    repeat (2) @(posedge pclk);
    cmp(irq, 0);
    // short frame: entering running loads, zero reloads the new length
    v = {1'b1, 15'($urandom), 2'b0, 14'd20};
    apb(1, 12'h034, v);
    state_wr <= 1;
    state_wdata <= 2'h2;
    @(posedge pclk);
    state_wr <= 0;
    wait_hi(1);
    cmp({ldp_counter, fc_toggle, fc_count}, {v[30:16], 1'b1, 14'd20});
    apb(1, 12'h034, {1'b0, v[30:16], 16'd9});
    wait_hi(1);
    cmp({frame_counter, fc_toggle, fc_count}, {16'd2, 1'b0, 14'd9});
    rchk(12'h080, 32'h0000_0006);
    rchk(12'h084, 32'h0000_0002);
    stop_test();
  end
endmodule : uhl_regs_bench
